// File: afc_pkg.sv
// Constants and types for the ADC frame and sample control block
// Functional notes
// - Chip select high: output tristated, input ignored
// - Chip select fall clears counter, opens port
// - Frame sync high at select: start cycle
// - Frame sync low: start at frame sync rise
// - Extended mode: trigger fall starts sampling
// - Extended mode: trigger rise holds, converts
// - Trigger acts regardless of clock, select, sync
// - Status is end-of-conversion only in mode 00
// - End-of-conversion low from sampling end to ready
// - Interrupt falls when data is ready
// - Interrupt cleared by select, sync, trigger edges
// - Frame sync start clears counter, opens port
// - Output tristates at sixteenth falling clock edge
package afc_pkg;
  localparam logic [1:0] AFC_MODE_EOC = 2'h0;
  localparam logic [3:0] AFC_CNT_RESET = 4'h0;
  localparam logic [3:0] AFC_LAST_EDGE = 4'hf;
  localparam logic [3:0] AFC_SAMPLE_EDGE = 4'h4;
  localparam int AFC_CONV_CYCLES_DEF = 64;
  typedef enum logic [1:0] {AFC_IDLE, AFC_SAMPLE, AFC_CONVERT} afc_conv_type;
endpackage

// File: afc_sync.sv
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
module afc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  initial begin
    if (WIDTH < 1) begin
      $error("WIDTH must be at least 1");
    end
  end

  logic [WIDTH-1:0] stage1;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// File: afc_top.sv
// Frame and sample control: framing, sampling and status output
`timescale 1ns/10ps
module afc_top import afc_pkg::*; #(
  parameter int CONV_CYCLES = AFC_CONV_CYCLES_DEF
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Serial link pins
  input wire logic i_chip_select_n,
  input wire logic i_frame_sync,
  input wire logic i_serial_clock,
  input wire logic i_serial_data_in,
  input wire logic i_sample_trigger_n,
  // Configuration from the command decoder
  input wire logic [1:0] i_conv_mode,
  input wire logic i_ext_sampling,
  input wire logic i_sclk_conv_clock,
  input wire logic i_tx_bit,
  // Serial output pin
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe,
  // Status pin and internal view
  output logic o_status_n,
  output logic o_frame_active,
  output logic o_rx_bit_valid,
  output logic o_rx_bit,
  output logic o_conv_done,
  output logic o_conv_clock_tick
);
  initial begin
    if (CONV_CYCLES < 2 || CONV_CYCLES > 65535) begin
      $error("CONV_CYCLES out of range");
    end
  end

  logic rst_meta, rst_n;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Pins pass two flip-flops; the synchroniser leaves reset two edges before the
  // edge flops, so it already shows the real pin levels and no false select or trigger edge follows
  logic [4:0] pins_s;
  afc_sync #(.WIDTH(5)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_chip_select_n, i_frame_sync, i_serial_clock, i_serial_data_in,
              i_sample_trigger_n}),
    .o_sync(pins_s)
  );
  wire cs_s = pins_s[4] | ~rst_n;
  wire fs_s = pins_s[3];
  wire sclk_s = pins_s[2];
  wire sdi_s = pins_s[1];
  wire trig_s = pins_s[0] | ~rst_n;

  logic cs_d, fs_d, sclk_d, trig_d;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d <= 1'b1;
      fs_d <= 1'b0;
      sclk_d <= 1'b0;
      trig_d <= 1'b1;
    end else begin
      cs_d <= cs_s;
      fs_d <= fs_s;
      sclk_d <= sclk_s;
      trig_d <= trig_s;
    end
  end

  wire cs_fall = cs_d & ~cs_s;
  wire fs_rise = ~fs_d & fs_s;
  wire sclk_rise = ~sclk_d & sclk_s;
  wire sclk_fall = sclk_d & ~sclk_s;
  wire trig_fall = trig_d & ~trig_s;
  wire trig_rise = ~trig_d & trig_s;

  // Framing
  logic armed, active, sdo_en, tx_reg, status_n, rx_valid, rx_bit, conv_tick;
  logic [3:0] edge_cnt;
  wire start_cs = cs_fall & fs_s;
  wire start_fs = fs_rise & ~cs_s & (armed | active);
  wire frame_start = start_cs | start_fs;
  wire last_edge = active & sclk_fall & (edge_cnt == AFC_LAST_EDGE);
  wire eoc_mode = (i_conv_mode == AFC_MODE_EOC);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
      active <= 1'b0;
      edge_cnt <= AFC_CNT_RESET;
    end else if (cs_s) begin
      armed <= 1'b0;
      active <= 1'b0;
    end else if (frame_start) begin
      armed <= 1'b0;
      active <= 1'b1;
      edge_cnt <= AFC_CNT_RESET;
    end else begin
      if (cs_fall) begin
        armed <= 1'b1;
        edge_cnt <= AFC_CNT_RESET;
      end
      if (last_edge) begin
        active <= 1'b0;
      end else if (active && sclk_fall) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  // Output leaves high impedance at select fall, returns at 16th fall
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_en <= 1'b0;
      tx_reg <= 1'b0;
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
      conv_tick <= 1'b0;
    end else begin
      if (cs_s || last_edge) begin
        sdo_en <= 1'b0;
      end else if (cs_fall || frame_start) begin
        sdo_en <= 1'b1;
      end
      tx_reg <= i_tx_bit;
      rx_valid <= active & ~cs_s & sclk_fall;
      rx_bit <= sdi_s;
      conv_tick <= i_sclk_conv_clock & sclk_rise;
    end
  end

  // Sampling and conversion sequencer
  afc_conv_type conv_state, next_conv_state;
  logic [15:0] conv_cnt;
  logic conv_done;
  wire normal_sample = ~i_ext_sampling & active & sclk_fall & (edge_cnt == AFC_SAMPLE_EDGE);
  wire sample_start = i_ext_sampling ? trig_fall : normal_sample;
  wire sample_end = i_ext_sampling ? trig_rise : last_edge;
  wire conv_step = i_sclk_conv_clock ? sclk_rise : 1'b1;
  wire conv_finish = (conv_state == AFC_CONVERT) && conv_step &&
                     (conv_cnt == 16'(CONV_CYCLES - 1));

  always_comb begin
    next_conv_state = conv_state;
    unique case (conv_state)
      AFC_IDLE: if (sample_start) next_conv_state = AFC_SAMPLE;
      AFC_SAMPLE: if (sample_end) next_conv_state = AFC_CONVERT;
      AFC_CONVERT: if (conv_finish) next_conv_state = AFC_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_state <= AFC_IDLE;
      conv_cnt <= 16'h0000;
      conv_done <= 1'b0;
    end else begin
      conv_state <= next_conv_state;
      conv_done <= conv_finish;
      if (conv_state != AFC_CONVERT) begin
        conv_cnt <= 16'h0000;
      end else if (conv_step) begin
        conv_cnt <= conv_cnt + 16'h0001;
      end
    end
  end

  // Status: end-of-conversion or interrupt; a new event wins over a clear
  wire int_clear = cs_fall | fs_rise | trig_fall;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_n <= 1'b1;
    end else if (eoc_mode) begin
      if (conv_state == AFC_SAMPLE && sample_end) begin
        status_n <= 1'b0;
      end else if (conv_finish) begin
        status_n <= 1'b1;
      end
    end else if (conv_finish) begin
      status_n <= 1'b0;
    end else if (int_clear) begin
      status_n <= 1'b1;
    end
  end

  assign o_serial_data_out = tx_reg;
  assign o_serial_data_out_oe = sdo_en;
  assign o_status_n = status_n;
  assign o_frame_active = active;
  assign o_rx_bit_valid = rx_valid;
  assign o_rx_bit = rx_bit;
  assign o_conv_done = conv_done;
  assign o_conv_clock_tick = conv_tick;

  chk_tristate_select: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    cs_s |=> !sdo_en) else $error("output driven while deselected");
  chk_open_on_select: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (cs_fall && !cs_s) |=> sdo_en) else $error("output not opened");
  chk_start_on_select: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    start_cs |=> active && edge_cnt == AFC_CNT_RESET) else $error("no start");
  chk_wait_sync: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (cs_fall && !fs_s) |=> !active) else $error("started without sync");
  chk_ext_sample: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_ext_sampling && trig_fall && conv_state == AFC_IDLE) |=>
    conv_state == AFC_SAMPLE) else $error("trigger ignored");
  chk_ext_hold: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (i_ext_sampling && trig_rise && conv_state == AFC_SAMPLE) |=>
    conv_state == AFC_CONVERT) else $error("no conversion");
  chk_eoc_low: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (eoc_mode && conv_state == AFC_CONVERT && !conv_finish && $stable(i_conv_mode)) |=>
    !status_n)
    else $error("eoc not low");
  chk_int_fall: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (!eoc_mode && conv_finish) |=> !status_n) else $error("no interrupt");
  chk_int_clear: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    (!eoc_mode && int_clear && !conv_finish) |=> status_n) else $error("not cleared");
  chk_sixteen_edges: assert property (@(posedge i_ref_clk) disable iff (!rst_n)
    last_edge |=> !sdo_en && !active) else $error("no close");
  cov_frame_cs: cover property (@(posedge i_ref_clk) disable iff (!rst_n) start_cs);
  cov_frame_fs: cover property (@(posedge i_ref_clk) disable iff (!rst_n) start_fs);
  cov_conv: cover property (@(posedge i_ref_clk) disable iff (!rst_n) conv_finish);
endmodule

// File: afc_host.sv
// Host serial port model: framing, serial clock and sample trigger
`timescale 1ns/10ps
module afc_host (
  // Pins toward the device
  output logic o_chip_select_n,
  output logic o_frame_sync,
  output logic o_serial_clock,
  output logic o_serial_data_in,
  output logic o_sample_trigger_n
);
  initial begin
    o_chip_select_n = 1'b1;
    o_frame_sync = 1'b1;
    o_serial_clock = 1'b0;
    o_serial_data_in = 1'b1;
    o_sample_trigger_n = 1'b1;
  end
  // Serial clock idles low except inside clocks, which the bench also calls between frames
  task automatic clocks(input int n);
    for (int k = 0; k < n; k++) begin
      o_serial_clock = 1'b1;
      o_serial_data_in = ~o_serial_data_in;
      #40;
      o_serial_clock = 1'b0;
      #40;
    end
  endtask
  task automatic select(input logic fs_high);
    o_frame_sync = fs_high;
    #40 o_chip_select_n = 1'b0;
    #100;
  endtask
  task automatic start();
    o_frame_sync = 1'b1;
    #100;
  endtask
  task automatic deselect();
    #40 o_chip_select_n = 1'b1;
  endtask
  // Low time sets sampling; high time must cover conversion
  task automatic trigger(input logic v);
    o_sample_trigger_n = v;
  endtask
endmodule

// File: afc_top_tb.sv
// Self-checking bench for the frame and sample control block
`timescale 1ns/10ps
module afc_top_tb;
  import afc_pkg::*;
  typedef struct {logic fs_high; logic [1:0] mode; logic st; logic sc;} afc_row_type;
  logic i_ref_clk, i_reset_n, cs_n, fs, sclk, serial_data_in, trig_n, i_ext_sampling, i_tx_bit;
  logic [1:0] i_conv_mode;
  logic oe, status_n, active, rxv, done, serial_data_out, rx, tick, conv_on_sclk;
  int bad_count, n_compared, rx_n, done_n, lo_n, tick_n, ones_n, oe_n;
  afc_row_type rows[4] = '{'{1'b1, 2'h0, 1'b1, 1'b0}, '{1'b0, 2'h1, 1'b0, 1'b0},
    '{1'b1, 2'h2, 1'b0, 1'b1}, '{1'b0, 2'h3, 1'b0, 1'b0}};
  afc_host afc_host_i (.o_chip_select_n(cs_n), .o_frame_sync(fs), .o_serial_clock(sclk),
    .o_serial_data_in(serial_data_in), .o_sample_trigger_n(trig_n));
  afc_top #(.CONV_CYCLES(4)) afc_top_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_chip_select_n(cs_n), .i_frame_sync(fs), .i_serial_clock(sclk),
    .i_serial_data_in(serial_data_in), .i_sample_trigger_n(trig_n), .i_conv_mode(i_conv_mode),
    .i_ext_sampling(i_ext_sampling), .i_sclk_conv_clock(conv_on_sclk), .i_tx_bit(i_tx_bit),
    .o_serial_data_out(serial_data_out), .o_serial_data_out_oe(oe), .o_status_n(status_n),
    .o_frame_active(active), .o_rx_bit_valid(rxv), .o_rx_bit(rx), .o_conv_done(done),
    .o_conv_clock_tick(tick));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    rx_n += (rxv === 1'b1);
    done_n += (done === 1'b1);
    lo_n += (status_n === 1'b0);
    tick_n += (tick === 1'b1);
    ones_n += (rxv === 1'b1 && rx === 1'b1);
    oe_n += (oe === 1'b1);
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for the end-of-conversion pulse
  task automatic wait_done();
    int k;
    for (k = 0; k < 400 && done_n == 0; k++) @(negedge i_ref_clk);
    if (k == 400) begin
      cmp(8'h0, 8'h1);
    end
    repeat (5) @(negedge i_ref_clk);
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_conv_mode = 2'h0;
    i_ext_sampling = 1'b0;
    i_tx_bit = 1'b0;
    conv_on_sclk = 1'b0;
    repeat (16) @(negedge i_ref_clk);
    cmp(status_n, 8'h1);
    cmp(oe, 8'h0);
    i_reset_n = 1'b1;
    repeat (8) @(negedge i_ref_clk);
    cmp(oe_n[7:0], 8'h0);
    foreach (rows[r]) begin
      i_conv_mode = rows[r].mode;
      conv_on_sclk = rows[r].sc;
      i_tx_bit = ~i_tx_bit;
      tick_n = 0;
      ones_n = 0;
      afc_host_i.select(rows[r].fs_high);
      rx_n = 0;
      done_n = 0;
      lo_n = 0;
      cmp(oe, 8'h1);
      cmp(serial_data_out, {7'h0, i_tx_bit});
      cmp(status_n, 8'h1);
      cmp(active, {7'h0, rows[r].fs_high});
      afc_host_i.start();
      cmp(active, 8'h1);
      afc_host_i.clocks(16);
      repeat (10) @(negedge i_ref_clk);
      cmp(rx_n[7:0], 8'h10);
      cmp(ones_n[7:0], 8'h8);
      cmp(oe, 8'h0);
      // Conversion on the serial clock goes on while deselected
      if (rows[r].sc) begin
        afc_host_i.deselect();
        afc_host_i.clocks(4);
      end
      wait_done();
      cmp(tick_n[7:0], rows[r].sc ? 8'h14 : 8'h0);
      cmp(lo_n != 0, 8'h1);
      cmp(status_n, {7'h0, rows[r].st});
      afc_host_i.deselect();
      $display("row %0d done", r);
    end
    conv_on_sclk = 1'b0;
    i_ext_sampling = 1'b1;
    i_conv_mode = 2'h1;
    done_n = 0;
    afc_host_i.trigger(1'b0);
    #300;
    cmp(status_n, 8'h1);
    cmp(done_n[7:0], 8'h0);
    afc_host_i.trigger(1'b1);
    wait_done();
    cmp(status_n, 8'h0);
    $display("trigger test done");
    // Deselect in mid-frame: the port closes and later clock falls are ignored
    rx_n = 0;
    afc_host_i.select(1'b1);
    afc_host_i.clocks(4);
    afc_host_i.deselect();
    repeat (6) @(negedge i_ref_clk);
    cmp(active, 8'h0);
    afc_host_i.clocks(4);
    cmp(rx_n[7:0], 8'h4);
    cmp(oe, 8'h0);
    $display("deselected clock test done");
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    cmp(status_n, 8'h1);
    // Release with idle pins: no false select or trigger edge may follow
    i_reset_n = 1'b1;
    oe_n = 0;
    done_n = 0;
    repeat (20) @(negedge i_ref_clk);
    cmp(oe_n[7:0], 8'h0);
    cmp(done_n[7:0], 8'h0);
    $display("second reset test done");
    finish_test();
  end
endmodule
